// File: shared/ect_defs.svh
// Constants for the buffered input capture timer
`ifndef ECT_DEFS_SVH
`define ECT_DEFS_SVH
`define CNT_W 16
`define PACC_W 8
`define NUM_CH 8
`define NUM_BUF 4
`define CNT_RST 16'h0000
`define PACC_RST 8'h00
`define FLAG_RST 8'h00
// Glitch filter lengths in sys_clk cycles, one per delay selection
`define DLY_OFF 5'h01
`define DLY_SHORT 5'h04
`define DLY_MID 5'h08
`define DLY_LONG 5'h10
// Modulus prescaler tap masks: divide by 1, 4, 8, 16
`define MOD_DIV1 4'h0
`define MOD_DIV4 4'h3
`define MOD_DIV8 4'h7
`define MOD_DIV16 4'hf
`endif

// File: shared/ect_pkg.sv
// Types shared by the capture timer modules
package ect_pkg;
    typedef enum logic [1:0] {EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_ANY} edge_mode_t;
    typedef logic [15:0] count_t;
endpackage : ect_pkg

// File: shared/chan_if.sv
// Signals between the timer core and one capture channel
`timescale 1ns/100ps
interface chan_if;
    import ect_pkg::*;
    logic pin;
    edge_mode_t edge_mode;
    logic [1:0] delay_sel;
    logic is_capture;
    logic no_overwrite;
    logic queue_mode;
    logic latch_evt;
    logic cap_read;
    logic hold_read;
    count_t counter;
    logic active_edge;
    logic event_hit;
    count_t cap_value;
    count_t hold_value;
    modport ctrl (output pin, edge_mode, delay_sel, is_capture, no_overwrite, queue_mode,
        latch_evt, cap_read, hold_read, counter, input active_edge, event_hit, cap_value,
        hold_value);
    modport chan (input pin, edge_mode, delay_sel, is_capture, no_overwrite, queue_mode,
        latch_evt, cap_read, hold_read, counter, output active_edge, event_hit, cap_value,
        hold_value);
endinterface : chan_if

// File: core/capture_channel.sv
// One capture channel: glitch filter, edge detect, capture and holding register
`timescale 1ns/100ps
`include "ect_defs.svh"
module capture_channel import ect_pkg::*; #(
    parameter bit BUFFERED = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    chan_if.chan ch
);
    logic [4:0] dly_q, dly_d, need;
    logic filt_q, filt_d, rise, fall, accept;
    logic cap_full_q, cap_full_d, hold_full_q, hold_full_d;
    count_t cap_q, cap_d, hold_q, hold_d;

    // Delay counter: the pin must hold a new level for the selected time
    always_comb begin
        case (ch.delay_sel)
            2'h0: need = `DLY_OFF;
            2'h1: need = `DLY_SHORT;
            2'h2: need = `DLY_MID;
            default: need = `DLY_LONG;
        endcase
        filt_d = filt_q;
        dly_d = 5'h00;
        if (ch.pin != filt_q) begin
            if (dly_q + 5'h01 >= need) begin
                filt_d = ch.pin;
            end else begin
                dly_d = dly_q + 5'h01;
            end
        end
        rise = filt_d & ~filt_q;
        fall = ~filt_d & filt_q;
        ch.active_edge = (rise && (ch.edge_mode == EDGE_RISE || ch.edge_mode == EDGE_ANY)) ||
            (fall && (ch.edge_mode == EDGE_FALL || ch.edge_mode == EDGE_ANY));
    end

    // Capture, latch and queue transfers; reads mark registers empty
    always_comb begin
        cap_d = cap_q;
        hold_d = hold_q;
        cap_full_d = cap_full_q & ~ch.cap_read;
        hold_full_d = hold_full_q & ~ch.hold_read;
        accept = 1'b0;
        if (BUFFERED && ch.latch_evt && cap_full_q && !(ch.no_overwrite && hold_full_d)) begin
            hold_d = cap_q;
            hold_full_d = 1'b1;
            cap_full_d = 1'b0;
        end
        if (ch.is_capture && ch.active_edge) begin
            if (BUFFERED && ch.queue_mode) begin
                if (!ch.no_overwrite || !cap_full_d) begin
                    accept = 1'b1;
                    if (cap_full_d || !ch.no_overwrite) begin
                        hold_d = cap_q;
                        hold_full_d = 1'b1;
                    end
                end else if (!hold_full_d) begin
                    accept = 1'b1;
                    hold_d = cap_q;
                    hold_full_d = 1'b1;
                end
            end else if (!ch.no_overwrite || !cap_full_d) begin
                accept = 1'b1;
            end
        end
        if (accept) begin
            cap_d = ch.counter;
            cap_full_d = 1'b1;
        end
        ch.event_hit = accept;
    end

    // Channel state registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dly_q <= 5'h00;
            filt_q <= 1'b0;
            cap_q <= `CNT_RST;
            hold_q <= `CNT_RST;
            cap_full_q <= 1'b0;
            hold_full_q <= 1'b0;
        end else begin
            dly_q <= dly_d;
            filt_q <= filt_d;
            cap_q <= cap_d;
            hold_q <= BUFFERED ? hold_d : `CNT_RST;
            cap_full_q <= cap_full_d;
            hold_full_q <= BUFFERED ? hold_full_d : 1'b0;
        end
    end

    assign ch.cap_value = cap_q;
    assign ch.hold_value = hold_q;

    ////////////////////////////////////////////////////////////////////////////////
    chk_cap_store: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ch.event_hit |=> (cap_q == $past(ch.counter)))
        else $error("capture register missed the counter value");
    chk_novw_keep: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (ch.no_overwrite && cap_full_q && !ch.cap_read && !ch.latch_evt
        && !(BUFFERED && ch.queue_mode))
        |=> $stable(cap_q))
        else $error("full capture register overwritten");
    chk_queue_shift: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (BUFFERED && ch.queue_mode && !ch.no_overwrite && ch.event_hit)
        |=> (hold_q == $past(cap_q)))
        else $error("queue shift into holding register missing");
    chk_read_empty: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (ch.cap_read && !ch.event_hit) ##1 (ch.is_capture && ch.active_edge && ch.no_overwrite
        && !(BUFFERED && ch.queue_mode)) |-> ch.event_hit)
        else $error("read capture register not treated as empty");
endmodule : capture_channel

// File: core/buffered_input_capture_timer.sv
// Input capture timer core: counters, flags, pulse accumulators, eight channels
`timescale 1ns/100ps
`include "ect_defs.svh"
module buffered_input_capture_timer import ect_pkg::*; #(
    parameter int NUM_CH = `NUM_CH,
    parameter int NUM_BUF = `NUM_BUF
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [NUM_CH-1:0] capture_pin,
    input wire logic [NUM_CH-1:0] capture_compare_select_reg,
    input wire logic [NUM_CH-1:0] overwrite_control_reg,
    input wire logic [2*NUM_CH-1:0] edge_mode,
    input wire logic [1:0] delay_sel,
    input wire logic latch_queue_select,
    input wire logic force_latch_bit,
    input wire logic main_enable,
    input wire logic [2:0] main_presc_sel,
    input wire logic mod_enable,
    input wire logic mod_periodic,
    input wire logic [1:0] mod_presc_sel,
    input wire logic [15:0] mod_load_value,
    input wire logic mod_load_wr,
    input wire logic mod_flag_clr,
    input wire logic [1:0] pacc_pair16,
    input wire logic pacc_saturate,
    input wire logic [NUM_CH-1:0] cap_read,
    input wire logic [NUM_BUF-1:0] hold_read,
    input wire logic flag_reg_read,
    input wire logic flag_write,
    input wire logic [NUM_CH-1:0] flag_write_data,
    output logic [15:0] main_count_q,
    output logic [15:0] mod_count_q,
    output logic mod_flag_q,
    output logic [NUM_CH-1:0] channel_flag_reg,
    output count_t [NUM_CH-1:0] channel_value_registers,
    output count_t [NUM_BUF-1:0] hold_value,
    output logic [NUM_BUF-1:0][7:0] pacc_q,
    output logic [NUM_BUF-1:0][7:0] pacc_hold_q
);
    logic [6:0] main_pre_q, main_pre_d, main_mask;
    logic [15:0] main_count_d, mod_count_d;
    logic [3:0] mod_pre_q, mod_pre_d, mod_mask;
    logic main_tick, mod_tick, zero_evt, latch_evt, mod_flag_d;
    logic [NUM_CH-1:0] flag_d, armed_q, armed_d, ev_vec, clr_mask;
    logic [NUM_BUF-1:0] pa_edge, pa_xfer;
    logic [NUM_BUF-1:0][7:0] pacc_d, pacc_hold_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Main counter: tick when the selected low prescaler bits are all ones
    always_comb begin
        main_mask = 7'((8'h01 << main_presc_sel) - 8'h01);
        main_tick = main_enable && ((main_pre_q & main_mask) == main_mask);
        main_pre_d = main_enable ? (main_pre_q + 7'h01) : main_pre_q;
        main_count_d = main_tick ? (main_count_q + 16'h0001) : main_count_q;
    end

    // Modulus down-counter with its own prescaler and zero event
    always_comb begin
        case (mod_presc_sel)
            2'h0: mod_mask = `MOD_DIV1;
            2'h1: mod_mask = `MOD_DIV4;
            2'h2: mod_mask = `MOD_DIV8;
            default: mod_mask = `MOD_DIV16;
        endcase
        mod_tick = mod_enable && ((mod_pre_q & mod_mask) == mod_mask);
        mod_pre_d = mod_enable ? (mod_pre_q + 4'h1) : mod_pre_q;
        mod_count_d = mod_count_q;
        zero_evt = 1'b0;
        if (mod_load_wr) begin
            mod_count_d = mod_load_value;
            mod_pre_d = 4'h0;
        end else if (mod_tick && mod_count_q != 16'h0000) begin
            mod_count_d = mod_count_q - 16'h0001;
            if (mod_count_q == 16'h0001) begin
                zero_evt = 1'b1;
                if (mod_periodic) begin
                    mod_count_d = mod_load_value;
                end
            end
        end
        mod_flag_d = (mod_flag_q & ~mod_flag_clr) | zero_evt;
        latch_evt = latch_queue_select && (zero_evt || force_latch_bit ||
            (mod_load_wr && mod_load_value == 16'h0000));
    end

    // Event flags: a read arms the set bits, a later write of ones clears them
    always_comb begin
        clr_mask = flag_write ? (flag_write_data & armed_q) : '0;
        flag_d = (channel_flag_reg & ~clr_mask) | ev_vec;
        armed_d = flag_reg_read ? channel_flag_reg : (flag_write ? '0 : armed_q);
    end

    // Pulse accumulators: 8-bit each, pairs chain into 16 bits
    always_comb begin
        logic [15:0] wide;
        wide = 16'h0000;
        pacc_d = pacc_q;
        pacc_hold_d = pacc_hold_q;
        for (int j = 0; j < NUM_BUF; j++) begin
            pa_xfer[j] = latch_evt || (!latch_queue_select && hold_read[j]);
            if (pa_xfer[j]) begin
                pacc_hold_d[j] = pacc_q[j];
                pacc_d[j] = `PACC_RST;
            end else if (pa_edge[j] && !(pacc_saturate && pacc_q[j] == 8'hff)) begin
                pacc_d[j] = pacc_q[j] + 8'h01;
            end
        end
        for (int p = 0; p < NUM_BUF / 2; p++) begin
            if (pacc_pair16[p]) begin
                wide = {pacc_q[2*p+1], pacc_q[2*p]};
                if (pa_xfer[2*p] || pa_xfer[2*p+1]) begin
                    pacc_hold_d[2*p] = pacc_q[2*p];
                    pacc_hold_d[2*p+1] = pacc_q[2*p+1];
                    wide = 16'h0000;
                end else if (pa_edge[2*p] && !(pacc_saturate && wide == 16'hffff)) begin
                    wide = wide + 16'h0001;
                end
                pacc_d[2*p] = wide[7:0];
                pacc_d[2*p+1] = wide[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Core state registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            main_pre_q <= 7'h00;
            main_count_q <= `CNT_RST;
            mod_pre_q <= 4'h0;
            mod_count_q <= `CNT_RST;
            mod_flag_q <= 1'b0;
            channel_flag_reg <= `FLAG_RST;
            armed_q <= `FLAG_RST;
            pacc_q <= '0;
            pacc_hold_q <= '0;
        end else begin
            main_pre_q <= main_pre_d;
            main_count_q <= main_count_d;
            mod_pre_q <= mod_pre_d;
            mod_count_q <= mod_count_d;
            mod_flag_q <= mod_flag_d;
            channel_flag_reg <= flag_d;
            armed_q <= armed_d;
            pacc_q <= pacc_d;
            pacc_hold_q <= pacc_hold_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Eight channels; the first four carry holding registers
    chan_if chi [NUM_CH] ();
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        assign chi[g].pin = capture_pin[g];
        assign chi[g].edge_mode = edge_mode_t'(edge_mode[2*g +: 2]);
        assign chi[g].delay_sel = delay_sel;
        assign chi[g].is_capture = ~capture_compare_select_reg[g];
        assign chi[g].no_overwrite = overwrite_control_reg[g];
        assign chi[g].queue_mode = ~latch_queue_select;
        assign chi[g].latch_evt = latch_evt;
        assign chi[g].cap_read = cap_read[g];
        assign chi[g].counter = main_count_q;
        assign ev_vec[g] = chi[g].event_hit;
        assign channel_value_registers[g] = chi[g].cap_value;
        if (g < NUM_BUF) begin : g_buf
            assign chi[g].hold_read = hold_read[g];
            assign hold_value[g] = chi[g].hold_value;
            assign pa_edge[g] = chi[g].active_edge;
        end else begin : g_plain
            assign chi[g].hold_read = 1'b0;
        end
        capture_channel #(.BUFFERED(g < NUM_BUF)) u_chan (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .ch(chi[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////////
    chk_flag_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (ev_vec != '0) |=> ((channel_flag_reg & $past(ev_vec)) == $past(ev_vec)))
        else $error("accepted capture did not set its flag");
    chk_flag_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
        1'b1 |=> ((~channel_flag_reg & $past(channel_flag_reg) & ~$past(clr_mask)) == '0))
        else $error("flag cleared without read and write-one");
    chk_main_tick: assert property (@(posedge sys_clk) disable iff (!rst_b)
        main_tick |=> (main_count_q == $past(main_count_q) + 16'h0001))
        else $error("main counter did not advance on prescaler tick");
    chk_mod_reload: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (zero_evt && mod_periodic) |=> (mod_count_q == $past(mod_load_value)) && mod_flag_q)
        else $error("modulus reload or flag missing");
    chk_pacc_xfer: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (pa_xfer[0] && !pacc_pair16[0]) |=> (pacc_q[0] == 8'h00) &&
        (pacc_hold_q[0] == $past(pacc_q[0])))
        else $error("accumulator transfer failed");
    chk_mod_step: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (mod_tick && !mod_load_wr && mod_count_q > 16'h0001)
        |=> (mod_count_q == $past(mod_count_q) - 16'h0001))
        else $error("modulus counter did not step down on its tick");
endmodule : buffered_input_capture_timer

// File: verif/capture_partner.sv
// Model of the capture pins and the polling software beside the capture timer
`timescale 1ns/100ps
module capture_partner import ect_pkg::*; (
    input wire logic sys_clk,
    input wire logic [15:0] main_count_q,
    output logic [7:0] capture_pin,
    output logic [7:0] cap_read,
    output logic [3:0] hold_read,
    output logic flag_reg_read,
    output logic flag_write,
    output logic [7:0] flag_write_data
);
    ////////////////////////////////////////////////////////////////////////////////
    // All lines idle low at time zero
    initial begin
        {capture_pin, cap_read, hold_read, flag_reg_read, flag_write, flag_write_data} = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flip one pin; the counter word is taken whole, never byte by byte
    task toggle(input int ch, output count_t stamp);
        @(negedge sys_clk);
        capture_pin[ch] = ~capture_pin[ch];
        stamp = main_count_q;
        @(negedge sys_clk);
    endtask : toggle

    // One-cycle software read of a capture or a holding register
    task read_reg(input bit hold, input int ch);
        @(negedge sys_clk);
        if (hold) begin
            hold_read[ch] = 1'h1;
        end else begin
            cap_read[ch] = 1'h1;
        end
        @(negedge sys_clk);
        cap_read = 8'h00;
        hold_read = 4'h0;
    endtask : read_reg

    // Write ones to flag bits, with or without the arming read first
    task write_flags(input logic [7:0] mask, input bit armed);
        @(negedge sys_clk);
        if (armed) begin
            flag_reg_read = 1'h1;
            @(negedge sys_clk);
            flag_reg_read = 1'h0;
        end
        flag_write = 1'h1;
        flag_write_data = mask;
        @(negedge sys_clk);
        flag_write = 1'h0;
        flag_write_data = ~mask; // Data no longer valid, so never show the old value
    endtask : write_flags
endmodule : capture_partner

// File: verif/buffered_input_capture_timer_test.sv
// Self-checking bench for the buffered input capture timer
`timescale 1ns/100ps
module buffered_input_capture_timer_test import ect_pkg::*;;
    logic sys_clk, rst_b, latch_queue_select, force_latch_bit, main_enable;
    logic mod_enable, mod_periodic, mod_load_wr, mod_flag_clr, pacc_saturate;
    logic flag_reg_read, flag_write, mod_flag_q;
    logic [7:0] capture_pin, capture_compare_select_reg, overwrite_control_reg, cap_read;
    logic [7:0] flag_write_data, channel_flag_reg;
    logic [15:0] edge_mode, mod_load_value, main_count_q, mod_count_q;
    logic [1:0] delay_sel, mod_presc_sel, pacc_pair16;
    logic [2:0] main_presc_sel;
    logic [3:0] hold_read;
    count_t [7:0] channel_value_registers;
    count_t [3:0] hold_value;
    logic [3:0][7:0] pacc_q, pacc_hold_q;
    count_t e, a, b;
    int miscompares = 0;
    int n_tests = 0;

    buffered_input_capture_timer uut (.sys_clk, .rst_b, .capture_pin,
        .capture_compare_select_reg, .overwrite_control_reg, .edge_mode, .delay_sel,
        .latch_queue_select, .force_latch_bit, .main_enable, .main_presc_sel, .mod_enable,
        .mod_periodic, .mod_presc_sel, .mod_load_value, .mod_load_wr, .mod_flag_clr,
        .pacc_pair16, .pacc_saturate, .cap_read, .hold_read, .flag_reg_read, .flag_write,
        .flag_write_data, .main_count_q, .mod_count_q, .mod_flag_q, .channel_flag_reg,
        .channel_value_registers, .hold_value, .pacc_q, .pacc_hold_q);
    capture_partner p (.sys_clk, .main_count_q, .capture_pin, .cap_read, .hold_read,
        .flag_reg_read, .flag_write, .flag_write_data);

    ////////////////////////////////////////////////////////////////////////////////
    // Compare and verdict
    task check_val(input count_t got, input count_t exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check_val
    task check_flag(input logic got, input logic exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask : check_flag
    task conclude;
        if (miscompares == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : conclude
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'h1;
        @(negedge sys_clk);
        s = 1'h0;
    endtask : pulse

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task capture_all;
        for (int g = 0; g < 8; g++) begin
            p.toggle(g, e);
            check_val(channel_value_registers[g], e, "capture value");
            check_flag(channel_flag_reg[g], 1'h1, "capture flag");
        end
    endtask : capture_all
    task flag_clear;
        p.write_flags(8'h0f, 1'h0);
        check_val({8'h00, channel_flag_reg}, 16'h00ff, "unarmed clear");
        p.write_flags(8'h0f, 1'h1);
        check_val({8'h00, channel_flag_reg}, 16'h00f0, "armed clear");
        p.write_flags(8'hf0, 1'h1);
        check_val({8'h00, channel_flag_reg}, 16'h0000, "armed clear high");
    endtask : flag_clear
    task compare_select;
        a = channel_value_registers[3];
        capture_compare_select_reg = 8'h08;
        p.toggle(3, e);
        check_val(channel_value_registers[3], a, "compare channel");
        check_flag(channel_flag_reg[3], 1'h0, "compare flag");
        capture_compare_select_reg = 8'h00;
    endtask : compare_select
    task overwrite;
        p.toggle(5, a);
        p.toggle(5, b);
        check_val(channel_value_registers[5], b, "overwrite");
        overwrite_control_reg = 8'h20;
        p.write_flags(8'hff, 1'h1);
        p.toggle(5, e);
        check_val(channel_value_registers[5], b, "kept unread");
        check_flag(channel_flag_reg[5], 1'h0, "refused flag");
        p.read_reg(1'h0, 5);
        p.toggle(5, e);
        check_val(channel_value_registers[5], e, "after read");
        check_flag(channel_flag_reg[5], 1'h1, "accepted flag");
        overwrite_control_reg = 8'h00;
    endtask : overwrite
    task latch_mode;
        latch_queue_select = 1'h1;
        pulse(force_latch_bit);
        for (int i = 0; i < 3; i++) p.toggle(0, e);
        pulse(force_latch_bit);
        check_val(hold_value[0], e, "force latch");
        check_val({pacc_hold_q[0], pacc_q[0]}, 16'h0300, "pacc latch");
        pacc_pair16 = 2'h1;
        pulse(force_latch_bit);
        for (int i = 0; i < 256; i++) p.toggle(0, e);
        check_val({pacc_q[1], pacc_q[0]}, 16'h0100, "paired carry");
        pacc_pair16 = 2'h0;
    endtask : latch_mode
    task modulus;
        mod_enable = 1'h1;
        mod_load_value = 16'h0003;
        p.toggle(1, a);
        pulse(mod_load_wr);
        for (int i = 0; i < 20 && mod_flag_q !== 1'h1; i++) @(negedge sys_clk);
        check_flag(mod_flag_q, 1'h1, "mod flag");
        check_val(mod_count_q, 16'h0000, "mod zero");
        check_val(hold_value[1], a, "zero latch");
        pulse(mod_flag_clr);
        check_flag(mod_flag_q, 1'h0, "mod flag clear");
        mod_load_value = 16'h0000;
        p.toggle(1, b);
        pulse(mod_load_wr);
        check_val(hold_value[1], b, "zero write latch");
    endtask : modulus
    task queue_mode;
        latch_queue_select = 1'h0;
        p.toggle(2, a);
        p.toggle(2, b);
        check_val(hold_value[2], a, "queue shift");
        check_val(channel_value_registers[2], b, "queue new");
        p.read_reg(1'h1, 2);
        check_val({8'h00, pacc_hold_q[2]}, 16'h0002, "queue pacc");
        overwrite_control_reg = 8'h04;
        p.toggle(2, e);
        check_val(hold_value[2], b, "hold empty after read");
        p.toggle(2, a);
        check_val(channel_value_registers[2], e, "both full refused");
        overwrite_control_reg = 8'h00;
    endtask : queue_mode
    task glitch_filter;
        delay_sel = 2'h1;
        p.write_flags(8'hff, 1'h1);
        p.toggle(6, e);
        p.toggle(6, e);
        repeat (6) @(negedge sys_clk);
        check_flag(channel_flag_reg[6], 1'h0, "glitch rejected");
        p.toggle(6, e);
        repeat (2) @(negedge sys_clk);
        check_flag(channel_flag_reg[6], 1'h0, "before filter time");
        @(negedge sys_clk);
        check_flag(channel_flag_reg[6], 1'h1, "at filter time");
        delay_sel = 2'h0;
    endtask : glitch_filter
    task edge_select;
        edge_mode = 16'h6fff;
        p.write_flags(8'hff, 1'h1);
        p.toggle(6, e);
        p.toggle(7, e);
        check_val({8'h00, channel_flag_reg}, 16'h0000, "wrong edge ignored");
        p.toggle(6, e);
        p.toggle(7, e);
        check_val(channel_value_registers[7], e, "rising edge capture");
        check_val({8'h00, channel_flag_reg}, 16'h00c0, "selected edges");
        edge_mode = 16'hffff;
    endtask : edge_select
    task prescale;
        main_presc_sel = 3'h3;
        a = main_count_q;
        repeat (16) @(negedge sys_clk);
        check_val(main_count_q, a + 16'h0002, "main prescale");
        main_presc_sel = 3'h0;
        mod_presc_sel = 2'h1;
        mod_periodic = 1'h1;
        mod_load_value = 16'h0002;
        pulse(mod_load_wr);
        repeat (7) @(negedge sys_clk);
        check_val(mod_count_q, 16'h0001, "mod prescale step");
        check_flag(mod_flag_q, 1'h0, "mod flag early");
        @(negedge sys_clk);
        check_val(mod_count_q, 16'h0002, "periodic reload");
        check_flag(mod_flag_q, 1'h1, "periodic flag");
        {mod_periodic, mod_enable, mod_presc_sel} = '0;
        pulse(mod_flag_clr);
    endtask : prescale
    task saturate;
        pacc_saturate = 1'h1;
        for (int i = 0; i < 260; i++) p.toggle(3, e);
        check_val({8'h00, pacc_q[3]}, 16'h00ff, "pacc saturate");
        pacc_saturate = 1'h0;
    endtask : saturate

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, watchdog and main sequence
    initial begin
        sys_clk = 1'h0;
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #500000;
        miscompares++;
        conclude();
    end
    initial begin
        {latch_queue_select, force_latch_bit, mod_enable, mod_periodic, mod_load_wr} = '0;
        {mod_flag_clr, pacc_saturate, capture_compare_select_reg} = '0;
        {overwrite_control_reg, delay_sel, mod_presc_sel, pacc_pair16, main_presc_sel} = '0;
        mod_load_value = 16'h0000;
        edge_mode = 16'hffff;
        main_enable = 1'h1;
        rst_b = 1'h0;
        repeat (10) @(negedge sys_clk);
        rst_b = 1'h1;
        capture_all();
        flag_clear();
        compare_select();
        overwrite();
        latch_mode();
        modulus();
        queue_mode();
        glitch_filter();
        edge_select();
        prescale();
        saturate();
        conclude();
    end
endmodule : buffered_input_capture_timer_test
